// ==== hdl/aai_top.sv ====
// Serial bus target, register file, comparator and alert/ready pin logic.
// Assumes the conversion core pulses conv_step on clk after each internal run.
`timescale 1ns/1ps
// Contract
// - Kind and latch selects ignored in ready use
// - Alert pin only pulls low or releases
// - Continuous mode gives 8 us ready pulse
// - Single-shot ready held until next start
// - Data rate selects third or fourth order
// - Single-shot ready after three or four runs
// - Latched alert held until read or response
// - Alert response sends address, lowest wins
// - Window mode alerts above high or below low threshold
// - Strap picks one of four target addresses
// - General call acknowledged on write
// - General call byte six resets, powers down
// - Master code unacknowledged, high speed until stop
// - Standard and fast speeds need no entry
// - Target never drives the serial clock
// - Pointer low three bits pick register
// - Result register read-only, resets to zero
// - Write is pointer, upper byte, lower byte
// - Read returns upper byte then lower byte
// - Polarity zero active low, one active high
// - Queue counts one, two, four; three disables
module aai_top
  import aai_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  // Serial bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Address strap sense
  input  wire logic [1:0]  strap_i,
  // Alert/ready pin
  output logic             alert_o,
  output logic             alert_oe,
  // Conversion core
  input  wire logic        conv_step,
  input  wire logic [15:0] conv_data,
  output logic             conv_start_q,
  output logic             power_down_q,
  output logic             filter4_q,
  output logic             hs_mode_q,
  output logic [15:0]      cfg_q,
  output logic [15:0]      cfg1_q,
  output logic [15:0]      trim_q
);

  aai_st_e     st_q;
  logic [2:0]  bit_q, ptr_q, steps_q, qcnt_q;
  logic [7:0]  sh_q, tx_q, hold_q;
  logic [1:0]  idx_q, own_lo_q;
  logic        rw_q, gc_q, ara_q, ackph_q, lo_sel_q, strap_ok_q;
  logic        scl_p_q, sda_p_q, busy_q, rdy_lvl_q, cmp_act_q;
  logic [15:0] result_q, lo_q, hi_q;
  logic [9:0]  rdy_cnt_q;
  logic [1:0]  pins_s, strap_s;
  logic        scl_s, sda_s;

  // Pin synchronisers
  aai_sync #(.W(2)) u_pins (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (en),
    .d     ({scl_i, sda_i}),
    .q     (pins_s)
  );
  aai_sync #(.W(2)) u_strap (
    .clk   (clk),
    .rst_n (rst_n),
    .en    (en),
    .d     (strap_i),
    .q     (strap_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Bus edges and conditions
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire [7:0] byte_in  = {sh_q[6:0], sda_s};
  wire       byte_done = scl_rise & (bit_q == 3'h7);
  wire [6:0] own_addr = {ADDR_BASE, own_lo_q};

  // Configuration fields
  wire       single  = cfg_q[CFG_MODE];
  wire       pol     = cfg_q[CFG_POL];
  wire       latch   = cfg_q[CFG_LAT];
  wire       win     = cfg_q[CFG_WIN];
  wire [1:0] que     = cfg_q[CFG_QUE_HI:0];
  wire [2:0] dr      = cfg_q[CFG_DR_HI:CFG_DR_LO];

  // Address byte decode
  wire addr_me  = byte_in[7:1] == own_addr;
  wire addr_ara = (byte_in == {ARA_ADDR, 1'b1}) & cmp_act_q & latch;
  wire addr_gc  = byte_in == GC_ADDR;
  wire addr_hs  = byte_in[7:3] == HS_CODE;
  wire in_addr  = (st_q == S_ADDR) & byte_done;

  // Write byte effects
  wire in_wr     = (st_q == S_WRITE) & byte_done;
  wire wr_ptr    = in_wr & ~gc_q & (idx_q == 2'h0);
  wire wr_commit = in_wr & ~gc_q & (idx_q == 2'h2);
  wire gc_rst    = in_wr & gc_q & (idx_q == 2'h0) & (byte_in == GC_RESET);
  wire [15:0] wdata = {hold_q, byte_in};

  // Read data selection
  wire [15:0] rd_word =
    (ptr_q == REG_RESULT) ? result_q :
    (ptr_q == REG_CFG)    ? {~busy_q, cfg_q[14:0]} :
    (ptr_q == REG_LO)     ? lo_q :
    (ptr_q == REG_HI)     ? hi_q :
    (ptr_q == REG_CFG1)   ? cfg1_q :
    (ptr_q == REG_ID)     ? ID_VALUE :
    (ptr_q == REG_TRIM)   ? trim_q : 16'h0000;

  // Alert response arbitration and clears
  wire tx_bit   = tx_q[~bit_q];
  wire ara_lost = (st_q == S_READ) & ara_q & scl_rise & tx_bit & ~sda_s;
  wire ara_win  = (st_q == S_READ) & ara_q & byte_done & ~ara_lost;
  wire rd_clr   = in_addr & addr_me & byte_in[0] & (ptr_q == REG_RESULT);

  // Conversion sequencing
  wire [2:0] steps_need = filter4_q ? STEPS_FOURTH : STEPS_THIRD;
  wire take    = conv_step & (~single | (busy_q & (steps_q == steps_need - 3'h1)));
  wire os_start = wr_commit & (ptr_q == REG_CFG) & wdata[CFG_OS] & wdata[CFG_MODE] & ~busy_q;
  wire pd_write = wr_commit & (ptr_q == REG_CFG1) & wdata[CFG1_PD];

  // Comparator
  wire out_hi = $signed(conv_data) > $signed(hi_q);
  wire out_lo = $signed(conv_data) < $signed(lo_q);
  wire trip   = win ? (out_hi | out_lo) : out_hi;
  wire [2:0] q_need = (que == QUE_ONE) ? 3'h1 : (que == QUE_TWO) ? 3'h2 : 3'h4;
  wire q_hit  = take & trip & (que != QUE_DIS) & (qcnt_q + 3'h1 >= q_need);
  wire cmp_clr = latch ? (rd_clr | ara_win) : (take & (win ? ~trip : out_lo));

  // Ready and pin level
  wire rdy_mode  = hi_q[15] & ~lo_q[15] & (que == QUE_ONE);
  wire rdy_act   = single ? rdy_lvl_q : (rdy_cnt_q != 10'h000);
  wire alert_act = rdy_mode ? rdy_act : ((que != QUE_DIS) & cmp_act_q);
  wire soft_rst  = ~rst_n | (en & gc_rst);

  // Pin and bus edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (en) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_ok_q <= 1'b0;
      own_lo_q   <= 2'h0;
    end else if (en && !strap_ok_q) begin
      strap_ok_q <= 1'b1;
      own_lo_q   <= strap_s;
    end
  end

  // Bus target state machine; plain speeds, clock only sampled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      idx_q <= 2'h0;
      {rw_q, gc_q, ara_q, ackph_q, lo_sel_q, hs_mode_q, sda_oe} <= 7'h00;
      sda_o <= 1'b0;
    end else if (en) begin
      if (start_c) begin
        st_q <= S_ADDR;
        bit_q <= 3'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        sda_oe <= 1'b0;
        hs_mode_q <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR: begin
            if (scl_rise) begin
              sh_q <= byte_in;
              bit_q <= bit_q + 3'h1;
            end
            if (byte_done) begin
              idx_q <= 2'h0;
              lo_sel_q <= 1'b0;
              ackph_q <= 1'b0;
              gc_q <= ~addr_me & ~addr_ara & addr_gc;
              ara_q <= ~addr_me & addr_ara;
              rw_q <= addr_me ? byte_in[0] : addr_ara;
              tx_q <= addr_me ? rd_word[15:8] : {own_addr, 1'b0};
              if (addr_me || addr_ara || addr_gc) begin
                st_q <= S_ACK;
              end else begin
                st_q <= S_IGNORE;
                hs_mode_q <= hs_mode_q | addr_hs;
              end
            end
          end
          S_ACK: begin
            if (scl_fall && !ackph_q) begin
              ackph_q <= 1'b1;
              sda_oe <= 1'b1;
            end else if (scl_fall) begin
              ackph_q <= 1'b0;
              bit_q <= 3'h0;
              st_q <= rw_q ? S_READ : S_WRITE;
              sda_oe <= rw_q & ~tx_q[7];
            end
          end
          S_WRITE: begin
            if (scl_rise) begin
              sh_q <= byte_in;
              bit_q <= bit_q + 3'h1;
            end
            if (byte_done) begin
              st_q <= S_ACK;
              idx_q <= (idx_q == 2'h2) ? 2'h1 : idx_q + 2'h1;
            end
          end
          S_READ: begin
            if (scl_fall) begin
              sda_oe <= ~tx_bit;
            end
            if (ara_lost) begin
              st_q <= S_IGNORE;
              sda_oe <= 1'b0;
            end else if (byte_done) begin
              st_q <= S_RACK;
            end else if (scl_rise) begin
              bit_q <= bit_q + 3'h1;
            end
          end
          S_RACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
            end
            if (scl_rise) begin
              st_q <= (sda_s || ara_q) ? S_IGNORE : S_READ;
              bit_q <= 3'h0;
              tx_q <= lo_sel_q ? rd_word[15:8] : rd_word[7:0];
              lo_sel_q <= ~lo_sel_q;
            end
          end
          default: sda_oe <= 1'b0;
        endcase
      end
    end
  end

  // pointer and byte holding; pointer persists
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_q <= REG_RESULT;
      hold_q <= 8'h00;
    end else if (en) begin
      if (wr_ptr) begin
        ptr_q <= byte_in[2:0];
      end
      if (in_wr && idx_q != 2'h2) begin
        hold_q <= byte_in;
      end
    end
  end

  // register file, reset by general call
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      cfg_q <= CFG_RST;
      lo_q <= LO_RST;
      hi_q <= HI_RST;
      cfg1_q <= CFG1_RST;
      trim_q <= TRIM_RST;
    end else if (en && wr_commit) begin
      if (ptr_q == REG_CFG) cfg_q <= {CFG_RST[CFG_OS], wdata[14:0]};
      else if (ptr_q == REG_LO) lo_q <= wdata;
      else if (ptr_q == REG_HI) hi_q <= wdata;
      else if (ptr_q == REG_CFG1) cfg1_q <= wdata & CFG1_MASK & ~(16'h0001 << CFG1_PD);
      else if (ptr_q == REG_TRIM) trim_q <= wdata & TRIM_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      busy_q <= 1'b0;
      steps_q <= 3'h0;
      result_q <= RESULT_RST;
      power_down_q <= 1'b1;
      conv_start_q <= 1'b0;
    end else if (en) begin
      conv_start_q <= os_start;
      if (os_start) begin
        busy_q <= 1'b1;
        steps_q <= 3'h0;
      end else if (take && single) begin
        busy_q <= 1'b0;
      end else if (conv_step && busy_q) begin
        steps_q <= steps_q + 3'h1;
      end
      if (take) result_q <= conv_data;
      if (os_start || !single) power_down_q <= 1'b0;
      else if (pd_write || (take && single)) power_down_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) filter4_q <= 1'b0;
    else if (en) filter4_q <= dr >= DR_FOURTH_MIN;
  end

  // queue count; alert state, set beats clear
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      qcnt_q <= 3'h0;
      cmp_act_q <= 1'b0;
    end else if (en) begin
      if (take) qcnt_q <= trip ? ((qcnt_q == 3'h4) ? qcnt_q : qcnt_q + 3'h1) : 3'h0;
      if (q_hit) cmp_act_q <= 1'b1;
      else if (cmp_clr) cmp_act_q <= 1'b0;
    end
  end

  // 8 us pulse; single-shot level until start
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      rdy_cnt_q <= 10'h000;
      rdy_lvl_q <= 1'b0;
    end else if (en) begin
      if (take && !single) rdy_cnt_q <= RDY_CYC;
      else if (rdy_cnt_q != 10'h000) rdy_cnt_q <= rdy_cnt_q - 10'h001;
      if (take && single) rdy_lvl_q <= 1'b1;
      else if (os_start || !single) rdy_lvl_q <= 1'b0;
    end
  end

  // open-drain pin with polarity; kind and latch ignored in ready use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alert_oe <= 1'b0;
      alert_o <= 1'b0;
    end else if (en) begin
      alert_oe <= pol ? ~alert_act : alert_act;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_pulse_load: assert property (en && take && !single && !soft_rst
    |=> rdy_cnt_q == RDY_CYC) else $error("ready pulse not loaded");
  a_single_ready_hold: assert property (en && rdy_lvl_q && single && !os_start && !gc_rst
    |=> rdy_lvl_q) else $error("single-shot ready dropped early");
  a_filter_order: assert property (en && !soft_rst
    |=> filter4_q == ($past(dr) >= DR_FOURTH_MIN)) else $error("wrong filter order");
  a_single_steps: assert property (en && conv_step && single && busy_q && !soft_rst
    && (steps_q < steps_need - 3'h1) |=> busy_q) else $error("single shot ended early");
  a_latch_hold: assert property (en && cmp_act_q && latch && !rd_clr && !ara_win && !gc_rst
    |=> cmp_act_q) else $error("latched alert dropped");
  a_ara_clear: assert property (en && ara_win && !q_hit && !gc_rst
    |=> !cmp_act_q) else $error("alert not cleared by response");
  a_own_addr_ack: assert property (en && in_addr && addr_me && !start_c && !stop_c
    |=> st_q == S_ACK) else $error("own address not acknowledged");
  a_gc_reset: assert property (en && gc_rst
    |=> cfg_q == CFG_RST && power_down_q) else $error("general call reset missed");
  a_hs_no_ack: assert property (en && in_addr && addr_hs && !start_c && !stop_c
    |=> st_q == S_IGNORE && hs_mode_q) else $error("master code handled wrong");
  a_ptr_persist: assert property (en && stop_c
    |=> ptr_q == $past(ptr_q)) else $error("pointer lost at stop");

  c_gc_reset:   cover property (en && gc_rst);
  c_ara_win:    cover property (en && ara_win);
  c_single_rdy: cover property (en && take && single);
  c_hs_entry:   cover property (en && in_addr && addr_hs);

endmodule

// ==== hdl/aai_pkg.sv ====
// Shared constants and types for the converter's serial target and alert pin.
// Assumes a 100 MHz core clock and 16-bit registers behind a 3-bit pointer.
package aai_pkg;

  // Register pointer values
  localparam logic [2:0] REG_RESULT = 3'h0;
  localparam logic [2:0] REG_CFG    = 3'h1;
  localparam logic [2:0] REG_LO     = 3'h2;
  localparam logic [2:0] REG_HI     = 3'h3;
  localparam logic [2:0] REG_CFG1   = 3'h4;
  localparam logic [2:0] REG_ID     = 3'h5;
  localparam logic [2:0] REG_TRIM   = 3'h6;

  // Reset values and writable masks
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] CFG_RST    = 16'h8583;
  localparam logic [15:0] LO_RST     = 16'h8000;
  localparam logic [15:0] HI_RST     = 16'h7fff;
  localparam logic [15:0] CFG1_RST   = 16'h0000;
  localparam logic [15:0] CFG1_MASK  = 16'h01d8;
  localparam logic [15:0] TRIM_RST   = 16'h01fa;
  localparam logic [15:0] TRIM_MASK  = 16'h07ff;
  // Identity word; value is arbitrary
  localparam logic [15:0] ID_VALUE   = 16'h0a5c;

  // Field positions of the two configuration words
  localparam int CFG_OS    = 15;
  localparam int CFG_MODE  = 8;
  localparam int CFG_DR_HI = 7;
  localparam int CFG_DR_LO = 5;
  localparam int CFG_WIN   = 4;
  localparam int CFG_POL   = 3;
  localparam int CFG_LAT   = 2;
  localparam int CFG_QUE_HI = 1;
  localparam int CFG1_PD   = 8;

  // Queue codes and data-rate boundary of the fourth-order filter
  localparam logic [1:0] QUE_ONE = 2'h0;
  localparam logic [1:0] QUE_TWO = 2'h1;
  localparam logic [1:0] QUE_DIS = 2'h3;
  localparam logic [2:0] DR_FOURTH_MIN = 3'h5;
  localparam logic [2:0] STEPS_THIRD   = 3'h3;
  localparam logic [2:0] STEPS_FOURTH  = 3'h4;

  // Bus address codes
  localparam logic [4:0] ADDR_BASE = 5'h12;
  localparam logic [6:0] ARA_ADDR  = 7'h0c;
  localparam logic [7:0] GC_ADDR   = 8'h00;
  localparam logic [7:0] GC_RESET  = 8'h06;
  localparam logic [4:0] HS_CODE   = 5'h01;

  // Ready pulse timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RDY_PULSE_NS  = 8000;
  localparam logic [9:0] RDY_CYC = 10'(RDY_PULSE_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACK, S_WRITE, S_READ, S_RACK, S_IGNORE
  } aai_st_e;

endpackage

// ==== hdl/aai_sync.sv ====
// Two-stage synchroniser for pin inputs, one stage pair per bit.
// Assumes inputs are asynchronous to clk; en freezes both stages.
// Stages keep tracking during reset, so the strap is settled at release.
`timescale 1ns/1ps
module aai_sync #(
  parameter int W = 1
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         en,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      // First stage feeds only the second; flushes while in reset
      always_ff @(posedge clk) begin
        if (!rst_n || en) begin
          meta_q <= d[i];
          q[i]   <= meta_q;
        end
      end
    end
  endgenerate

endmodule

// ==== tb/aai_i2c_master.sv ====
// Serial bus master model: drives the bus clock and pulls the data line.
// Assumes a pull-up on the data line, which reads as the AND of all pull-downs.
`timescale 1ns/1ps
module aai_i2c_master (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // 80 ns step, a third of the 240 ns bus clock period
  task automatic half();
    repeat (8) @(posedge clk);
  endtask

  // Start, or repeated start from a low clock
  task automatic start();
    sda <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sda <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b1;
    half();
  endtask

  // One bit, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    sda <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    half();
  endtask

  // byte out, most significant bit first
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // pat models a rival target pulling low, 8'hff when absent
  task automatic rd_byte(input logic [7:0] pat, input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(pat[i], r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// ==== tb/aai_top_test.sv ====
// Self-checking bench for the serial target and the alert/ready pin.
// Assumes the master model aai_i2c_master and pull-ups on both lines.
`timescale 1ns/1ps
module aai_top_test
  import aai_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        conv_step = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic [1:0]  strap = 2'h0;
  logic        scl, sda_m, sda_o, sda_oe, alert_o, alert_oe, ack;
  logic        conv_start_q, power_down_q, filter4_q, hs_mode_q;
  logic [15:0] cfg_q, cfg1_q, trim_q, v, x;
  logic [7:0]  b;
  logic [6:0]  me;
  wire         sda_line = sda_m & ~sda_oe;
  int          failures = 0;
  int          total_checks = 0;
  int          seed = 41;
  int          n;
  int          starts = 0;

  // Count single-shot start pulses
  always @(posedge clk) begin
    if (conv_start_q === 1'b1) starts++;
  end

  // 100 MHz clock
  always #5 clk = ~clk;

  aai_i2c_master i_mst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));

  aai_top i_dut (
    .clk(clk), .rst_n(rst_n), .en(1'b1), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .strap_i(strap), .alert_o(alert_o),
    .alert_oe(alert_oe), .conv_step(conv_step), .conv_data(conv_data),
    .conv_start_q(conv_start_q), .power_down_q(power_down_q), .filter4_q(filter4_q),
    .hs_mode_q(hs_mode_q), .cfg_q(cfg_q), .cfg1_q(cfg1_q), .trim_q(trim_q)
  );

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Reset for 5 cycles with the strap held steady
  task automatic do_reset(input logic [1:0] s);
    strap <= s;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // pointer with zero upper bits, then upper and lower byte
  task automatic wr_reg(input logic [2:0] p, input logic [15:0] d);
    i_mst.start();
    i_mst.wr_byte({me, 1'b0}, ack);
    i_mst.wr_byte({5'h00, p}, ack);
    i_mst.wr_byte(d[15:8], ack);
    i_mst.wr_byte(d[7:0], ack);
    i_mst.stop();
  endtask

  // Optional pointer write, repeated start, two bytes read
  task automatic rd_reg(input logic [2:0] p, input logic setp, output logic [15:0] d);
    i_mst.start();
    if (setp) begin
      i_mst.wr_byte({me, 1'b0}, ack);
      i_mst.wr_byte({5'h00, p}, ack);
      i_mst.start();
    end
    i_mst.wr_byte({me, 1'b1}, ack);
    i_mst.rd_byte(8'hff, 1'b1, d[15:8]);
    i_mst.rd_byte(8'hff, 1'b0, d[7:0]);
    i_mst.stop();
  endtask

  // One conversion run; counts cycles with alert_oe equal to val
  task automatic step(input logic [15:0] d, input int w, input logic val, output int c);
    c = 0;
    conv_step <= 1'b1;
    conv_data <= d;
    @(posedge clk);
    conv_step <= 1'b0;
    for (int i = 0; i < w; i++) begin
      @(posedge clk);
      if (alert_oe === val) c++;
    end
  endtask

  // Expected register contents after reset
  function automatic logic [15:0] rst_val(input logic [2:0] p);
    case (p)
      3'h1: return 16'h8583;
      3'h2: return 16'h8000;
      3'h3: return 16'h7fff;
      3'h5: return ID_VALUE;
      3'h6: return 16'h01fa;
      default: return 16'h0000;
    endcase
  endfunction

  // Runs before ready, and out-of-range results before alert
  function automatic int runs(input logic [2:0] dr);
    return (dr >= 3'h5) ? 4 : 3;
  endfunction
  function automatic int hits(input logic [1:0] q);
    return (q == 2'h2) ? 4 : int'(q) + 1;
  endfunction

  // Main sequence
  initial begin
    for (int s = 0; s < 4; s++) begin
      do_reset(2'(s));
      me = {5'h12, 2'(s)};
      i_mst.start();
      i_mst.wr_byte({me ^ 7'h01, 1'b0}, ack);
      check(16'(ack), 16'h0000);
      i_mst.start();
      i_mst.wr_byte({me, 1'b0}, ack);
      check(16'(ack), 16'h0001);
      i_mst.stop();
    end
    for (int p = 0; p < 8; p++) begin
      rd_reg(3'(p), 1'b1, v);
      check(v, rst_val(3'(p)));
    end
    x = 16'($random(seed));
    wr_reg(REG_RESULT, x);
    rd_reg(REG_LO, 1'b0, v);
    check(v, 16'h0000);
    wr_reg(REG_LO, x);
    rd_reg(REG_RESULT, 1'b0, v);
    check(v, x);
    wr_reg(REG_TRIM, x);
    check(trim_q, x & TRIM_MASK);
    $display("test registers done");
    wr_reg(REG_HI, 16'h8000 | x);
    wr_reg(REG_LO, 16'h7fff & x);
    for (int pol = 0; pol < 2; pol++) begin
      wr_reg(REG_CFG, 16'h0494 | {12'h000, 1'(pol), 3'h0});
      step(16'($random(seed)), 1000, ~1'(pol), n);
      check(16'(n), 16'd800);
      check(16'({alert_o, sda_o}), 16'h0000);
    end
    $display("test continuous ready done");
    wr_reg(REG_CFG, 16'h0100);
    for (int dr = 0; dr < 8; dr++) begin
      wr_reg(REG_CFG, 16'h8100 | {8'h00, 3'(dr), 5'h00});
      check(16'(filter4_q), 16'(dr >= 5));
      check(16'(alert_oe), 16'h0000);
      for (int k = 1; k <= runs(3'(dr)); k++) begin
        x = 16'($random(seed));
        step(x, 4, 1'b1, n);
        check(16'(alert_oe), 16'(k == runs(3'(dr))));
      end
      rd_reg(REG_RESULT, 1'b1, v);
      check(v, x);
      check(16'(alert_oe), 16'h0001);
    end
    check(16'(starts), 16'h0008);
    $display("test single-shot ready done");
    wr_reg(REG_HI, 16'h1000);
    wr_reg(REG_LO, 16'hf000);
    for (int q = 0; q < 4; q++) begin
      wr_reg(REG_CFG, 16'h0094 | 16'(q));
      step(16'h0000, 4, 1'b1, n);
      // host clears by reading the result
      rd_reg(REG_RESULT, 1'b1, v);
      check(16'(alert_oe), 16'h0000);
      for (int k = 1; k <= 4; k++) begin
        step(k[0] ? 16'h2000 : 16'he000, 4, 1'b1, n);
        check(16'(alert_oe), 16'(q < 3 && k >= hits(2'(q))));
      end
      step(16'h0000, 4, 1'b1, n);
      check(16'(alert_oe), 16'(q < 3));
    end
    $display("test comparator done");
    wr_reg(REG_CFG, 16'h0094);
    step(16'h2000, 4, 1'b1, n);
    for (int t = 0; t < 2; t++) begin
      i_mst.start();
      i_mst.wr_byte(8'h19, ack);
      i_mst.rd_byte(t ? 8'hff : 8'h90, 1'b0, b);
      i_mst.stop();
      check(16'(b), t ? 16'({me, 1'b0}) : 16'h0090);
      check(16'(alert_oe), 16'(t == 0));
    end
    $display("test alert response done");
    i_mst.start();
    i_mst.wr_byte(8'h00, ack);
    check(16'(ack), 16'h0001);
    i_mst.wr_byte(8'h06, ack);
    i_mst.stop();
    check(16'(power_down_q), 16'h0001);
    check(cfg_q, 16'h8583);
    rd_reg(REG_LO, 1'b1, v);
    check(v, 16'h8000);
    check(trim_q, 16'h01fa);
    check(cfg1_q, 16'h0000);
    $display("test general call done");
    i_mst.start();
    i_mst.wr_byte({5'h01, 3'($random(seed))}, ack);
    check(16'(ack), 16'h0000);
    check(16'(hs_mode_q), 16'h0001);
    i_mst.stop();
    check(16'(hs_mode_q), 16'h0000);
    $display("test speed modes done");
    complete_run();
  end
endmodule
